//--- logic/bcod_pkg.sv
/*
  package for the branch condition and opcode decoder: condition selectors,
  opcode low nibbles, flag positions and reset values.
  assumes nothing beyond a SystemVerilog compiler.
*/
package bcod_pkg;
  // condition selectors
  localparam logic [3:0] BSEL_NEVER = 4'h0;
  localparam logic [3:0] BSEL_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] BSEL_SIGNED_BELOW_OR_SAME = 4'h2;
  localparam logic [3:0] BSEL_UNSIGNED_BELOW_OR_SAME = 4'h3;
  localparam logic [3:0] BSEL_OVERFLOW = 4'h4;
  localparam logic [3:0] BSEL_MINUS = 4'h5;
  localparam logic [3:0] BSEL_ZERO = 4'h6;
  localparam logic [3:0] BSEL_CARRY = 4'h7;
  localparam logic [3:0] BSEL_ALWAYS = 4'h8;
  localparam logic [3:0] BSEL_SIGNED_ABOVE_OR_SAME = 4'h9;
  localparam logic [3:0] BSEL_SIGNED_ABOVE = 4'hA;
  localparam logic [3:0] BSEL_UNSIGNED_ABOVE = 4'hB;
  localparam logic [3:0] BSEL_NO_OVERFLOW_TEST = 4'hC;
  localparam logic [3:0] BSEL_PLUS = 4'hD;
  localparam logic [3:0] BSEL_NONZERO_TEST = 4'hE;
  localparam logic [3:0] BSEL_NO_CARRY = 4'hF;
  // opcode fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 4;
  localparam logic [3:0] LO_DEC_BRANCH = 4'hA;
  localparam logic [3:0] LO_REL_JUMP = 4'hB;
  localparam logic [3:0] LO_ABS_JUMP = 4'hD;
  localparam logic [7:0] OP_TRAP = 8'hF2;
  localparam logic [3:0] HI_XOR = 4'hB;
  localparam logic [3:0] HI_SUB_BORROW = 4'h3;
  localparam logic [3:0] LO_ALU_FIRST = 4'h2;
  localparam logic [3:0] LO_ALU_LAST = 4'h7;
  // flag byte layout: C Z S V D H
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  // stack pointer steps for trap
  localparam logic [15:0] TRAP_PC_STEP = 16'h0002;
  localparam logic [15:0] TRAP_FLAG_STEP = 16'h0001;
  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // trap sequencer states, gray coded
  typedef enum logic [1:0] {
    BCOD_IDLE = 2'b00,
    BCOD_PUSH_PC = 2'b01,
    BCOD_PUSH_FLAGS = 2'b11,
    BCOD_VECTOR = 2'b10
  } bcod_state_t;
endpackage : bcod_pkg

//--- logic/bcod_decoder.sv
/*
  branch condition evaluator and decoder for conditional jumps, decrement and
  branch, trap, exclusive-or and subtract with borrow.
  assumes the fetch stage presents a whole instruction (opcode, operands,
  displacement, destination, trap vector) with a one-cycle valid strobe and
  waits for done before the next one.
*/
`timescale 1ns/1ps
// How it works
// RULE_01: condition selector is opcode bits 7:4, sixteen flag tests.
// RULE_02: branch only when test true; 0000 never, 1000 always.
// RULE_03: 0001 S^V, 0010 Z|(S^V); 1001 and 1010 their inverses.
// RULE_04: 0011 C|Z, 0111 C, 1011 neither C nor Z, 1111 no carry.
// RULE_05: 0100 V, 0101 S, 1100/1101 inverses, 0110 Z, 1110 not Z.
// RULE_06: xD loads destination into PC when true; flags unchanged.
// RULE_07: xB adds signed displacement to PC when true; flags unchanged.
// RULE_08: xA decrements register; nonzero result adds displacement; flags kept.
// RULE_09: F2 pushes PC (SP-2), pushes flags (SP-3), loads vector into PC.
// RULE_10: B2-B7 xor into destination; Z,S follow, V cleared, C kept.
// RULE_11: 32-37 dst-src-C; C,Z,S,V,H follow result, D set to one.
// RULE_12: condition evaluation is combinational from current flags.
module bcod_decoder
  import bcod_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // instruction from fetch
  input wire logic INSTR_VALID_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [7:0] DST_I,
  input wire logic [7:0] SRC_I,
  input wire logic [7:0] DISP_I,
  input wire logic [15:0] DEST_ADDR_I,
  input wire logic [15:0] VECTOR_I,
  // cpu state in
  input wire logic [15:0] PC_I,
  input wire logic [15:0] SP_I,
  input wire logic [7:0] FLAGS_I,
  // results
  output logic DONE_O,
  output logic TAKEN_O,
  output logic PC_LOAD_O,
  output logic [15:0] PC_O,
  output logic SP_LOAD_O,
  output logic [15:0] SP_O,
  output logic FLAGS_LOAD_O,
  output logic [7:0] FLAGS_O,
  output logic RESULT_LOAD_O,
  output logic [7:0] RESULT_O,
  // stack writes
  output logic STACK_WR_O,
  output logic STACK_WORD_O,
  output logic [15:0] STACK_ADDR_O,
  output logic [15:0] STACK_DATA_O
);
  // condition selector and flags
  wire [3:0] sel = OPCODE_I[SEL_HI:SEL_LO]; // RULE_01
  wire [3:0] lo = OPCODE_I[3:0];
  wire c = FLAGS_I[FLAG_C];
  wire z = FLAGS_I[FLAG_Z];
  wire s = FLAGS_I[FLAG_S];
  wire v = FLAGS_I[FLAG_V];
  wire sxv = s ^ v;
  // eight base tests; the top selector bit inverts them
  wire signed_below = sxv; // RULE_03
  wire signed_below_or_same = z | sxv; // RULE_03
  wire unsigned_below_or_same = c | z; // RULE_04
  logic test; // RULE_12
  always_comb begin
    case (sel[2:0])
      3'h0: test = 1'b0; // RULE_02
      3'h1: test = signed_below; // RULE_03
      3'h2: test = signed_below_or_same; // RULE_03
      3'h3: test = unsigned_below_or_same; // RULE_04
      3'h4: test = v; // RULE_05
      3'h5: test = s; // RULE_05
      3'h6: test = z; // RULE_05
      default: test = c; // RULE_04
    endcase
  end
  wire cond_true = test ^ sel[3]; // RULE_02
  // instruction class decode
  wire go = INSTR_VALID_I;
  wire is_abs = go & (lo == LO_ABS_JUMP);
  wire is_rel = go & (lo == LO_REL_JUMP);
  wire is_decbr = go & (lo == LO_DEC_BRANCH);
  wire is_trap = go & (OPCODE_I == OP_TRAP);
  wire alu_lo = (lo >= LO_ALU_FIRST) && (lo <= LO_ALU_LAST);
  wire is_xor = go & alu_lo & (sel == HI_XOR) & ~is_trap;
  wire is_subb = go & alu_lo & (sel == HI_SUB_BORROW);
  // datapath
  wire [15:0] disp_ext = {{8{DISP_I[7]}}, DISP_I};
  wire [15:0] rel_target = PC_I + disp_ext;
  wire [7:0] dec_val = DST_I - 8'h01;
  wire decbr_nonzero = dec_val != 8'h00; // RULE_08
  wire [7:0] xor_val = DST_I ^ SRC_I; // RULE_10
  wire [8:0] subb_full = {1'b0, DST_I} - {1'b0, SRC_I} - {8'h00, c}; // RULE_11
  wire [4:0] subb_half = {1'b0, DST_I[3:0]} - {1'b0, SRC_I[3:0]} - {4'h0, c};
  wire [7:0] subb_val = subb_full[7:0];
  wire subb_ovf = (DST_I[7] ^ SRC_I[7]) & (DST_I[7] ^ subb_val[7]);
  logic [7:0] xor_flags;
  logic [7:0] subb_flags;
  always_comb begin
    xor_flags = FLAGS_I; // RULE_10
    xor_flags[FLAG_Z] = xor_val == 8'h00;
    xor_flags[FLAG_S] = xor_val[7];
    xor_flags[FLAG_V] = 1'b0;
    subb_flags = FLAGS_I; // RULE_11
    subb_flags[FLAG_C] = subb_full[8];
    subb_flags[FLAG_Z] = subb_val == 8'h00;
    subb_flags[FLAG_S] = subb_val[7];
    subb_flags[FLAG_V] = subb_ovf;
    subb_flags[FLAG_D] = 1'b1;
    subb_flags[FLAG_H] = subb_half[4];
  end
  // trap sequencer
  wire [15:0] sp_pc = SP_I - TRAP_PC_STEP; // RULE_09
  bcod_state_t state_r;
  bcod_state_t state_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  always_comb begin
    state_nxt = state_r;
    sp_nxt = sp_r;
    case (state_r)
      BCOD_IDLE: begin
        if (is_trap) begin
          state_nxt = BCOD_PUSH_PC;
          sp_nxt = sp_pc;
        end
      end
      BCOD_PUSH_PC: begin
        state_nxt = BCOD_PUSH_FLAGS;
        sp_nxt = sp_r - TRAP_FLAG_STEP; // RULE_09
      end
      BCOD_PUSH_FLAGS: state_nxt = BCOD_VECTOR;
      default: state_nxt = BCOD_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_r <= BCOD_IDLE;
      sp_r <= SP_RESET;
    end else begin
      state_r <= state_nxt;
      sp_r <= sp_nxt;
    end
  end
  wire idle = state_r == BCOD_IDLE;
  wire push_pc_st = state_r == BCOD_PUSH_PC;
  wire push_fl_st = state_r == BCOD_PUSH_FLAGS;
  wire vec_st = state_r == BCOD_VECTOR;
  // trap capture of pc, flags and vector
  logic [15:0] pc_hold_r;
  logic [7:0] flags_hold_r;
  logic [15:0] vec_r;
  wire capture = is_trap & idle;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pc_hold_r <= PC_RESET;
      flags_hold_r <= FLAGS_RESET;
      vec_r <= PC_RESET;
    end else if (capture) begin
      pc_hold_r <= PC_I;
      flags_hold_r <= FLAGS_I;
      vec_r <= VECTOR_I;
    end
  end
  // branch decisions
  wire take_abs = is_abs & cond_true; // RULE_06
  wire take_rel = is_rel & cond_true; // RULE_07
  wire take_decbr = is_decbr & decbr_nonzero; // RULE_08
  // next values of the outputs
  wire done_nxt = (idle & go & ~is_trap) | vec_st;
  wire taken_nxt = idle & (take_abs | take_rel | take_decbr);
  wire pc_load_nxt = taken_nxt | vec_st;
  wire [15:0] pc_nxt = vec_st ? vec_r : (take_abs ? DEST_ADDR_I : rel_target); // RULE_09
  wire flags_load_nxt = idle & (is_xor | is_subb);
  wire [7:0] flags_nxt = is_subb ? subb_flags : xor_flags;
  wire result_load_nxt = idle & (is_xor | is_subb | is_decbr); // RULE_08
  wire [7:0] result_nxt = is_subb ? subb_val : (is_decbr ? dec_val : xor_val);
  wire stack_wr_nxt = push_pc_st | push_fl_st; // RULE_09
  wire [15:0] stack_data_nxt = push_pc_st ? pc_hold_r : {8'h00, flags_hold_r};
  // strobes
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      DONE_O <= 1'b0;
      TAKEN_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      SP_LOAD_O <= 1'b0;
      FLAGS_LOAD_O <= 1'b0;
      RESULT_LOAD_O <= 1'b0;
      STACK_WR_O <= 1'b0;
      STACK_WORD_O <= 1'b0;
    end else begin
      DONE_O <= done_nxt;
      TAKEN_O <= taken_nxt;
      PC_LOAD_O <= pc_load_nxt;
      SP_LOAD_O <= vec_st;
      FLAGS_LOAD_O <= flags_load_nxt;
      RESULT_LOAD_O <= result_load_nxt;
      STACK_WR_O <= stack_wr_nxt;
      STACK_WORD_O <= push_pc_st;
    end
  end
  // data outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      PC_O <= PC_RESET;
      SP_O <= SP_RESET;
      FLAGS_O <= FLAGS_RESET;
      RESULT_O <= BYTE_RESET;
      STACK_ADDR_O <= SP_RESET;
      STACK_DATA_O <= PC_RESET;
    end else begin
      PC_O <= pc_nxt;
      SP_O <= sp_r;
      FLAGS_O <= flags_nxt;
      RESULT_O <= result_nxt;
      STACK_ADDR_O <= sp_r;
      STACK_DATA_O <= stack_data_nxt;
    end
  end
endmodule : bcod_decoder

//--- dv/bcod_cpu_model.sv
/* stack memory model of the cpu beside the decoder.
   assumes one-cycle stack write strobes from the decoder. */
`timescale 1ns/1ps
module bcod_cpu_model (
  input wire logic clk_i, rst_i, wr_i, word_i,
  input wire logic [15:0] addr_i, data_i,
  output logic [15:0] pc_word_o, pc_addr_o,
  output logic [7:0] flag_byte_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_word_o <= 16'h0000;
      pc_addr_o <= 16'h0000;
      flag_byte_o <= 8'h00;
    end else if (wr_i && word_i) begin
      pc_word_o <= data_i;
      pc_addr_o <= addr_i;
    end else if (wr_i) begin
      flag_byte_o <= data_i[7:0];
    end
  end
endmodule : bcod_cpu_model

//--- dv/bcod_decoder_checker.sv
/* assertions on the decoder ports.
   assumes bound to bcod_decoder. */
`timescale 1ns/1ps
module bcod_chk
  import bcod_pkg::*;
(
  input wire logic CORE_CLK_I, RST_I, INSTR_VALID_I, DONE_O, TAKEN_O, PC_LOAD_O, SP_LOAD_O,
  input wire logic FLAGS_LOAD_O, RESULT_LOAD_O, STACK_WR_O, STACK_WORD_O,
  input wire logic [7:0] OPCODE_I, DST_I, SRC_I, DISP_I, FLAGS_I, FLAGS_O, RESULT_O,
  input wire logic [15:0] DEST_ADDR_I, VECTOR_I, PC_I, SP_I, PC_O, SP_O, STACK_ADDR_O, STACK_DATA_O
);
  logic [2:0] tc_r;
  wire go = INSTR_VALID_I && tc_r == 3'h0;
  wire [3:0] lo = OPCODE_I[3:0];
  wire alu = go && lo >= LO_ALU_FIRST && lo <= LO_ALU_LAST;
  wire sv = FLAGS_I[FLAG_S] ^ FLAGS_I[FLAG_V];
  wire [7:0] tst = {FLAGS_I[FLAG_C], FLAGS_I[FLAG_Z], FLAGS_I[FLAG_S], FLAGS_I[FLAG_V],
    FLAGS_I[FLAG_C] | FLAGS_I[FLAG_Z], FLAGS_I[FLAG_Z] | sv, sv, 1'b0};
  wire ev = tst[OPCODE_I[6:4]] ^ OPCODE_I[7];
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) tc_r <= 3'h0;
    else if (go && OPCODE_I == OP_TRAP) tc_r <= 3'h3;
    else if (tc_r != 3'h0) tc_r <= tc_r - 3'h1;
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_pc;
    STACK_WR_O && STACK_WORD_O && STACK_ADDR_O == $past(SP_I, 2) - 16'h0002 && STACK_DATA_O == $past(PC_I, 2);
  endsequence
  sequence s_fl;
    STACK_WR_O && !STACK_WORD_O && STACK_ADDR_O == $past(SP_I, 3) - 16'h0003 && STACK_DATA_O[7:0] == $past(FLAGS_I, 3);
  endsequence
  AST_TRAP: assert property (go && OPCODE_I == OP_TRAP |=> !STACK_WR_O ##1 s_pc ##1 s_fl ##1
    (DONE_O && PC_O == $past(VECTOR_I, 4) && SP_LOAD_O && SP_O == $past(SP_I, 4) - 16'h0003)) else $error("trap wrong");
  AST_COND: assert property (go && (lo == LO_ABS_JUMP || lo == LO_REL_JUMP) |=> TAKEN_O == $past(ev))
    else $error("condition wrong");
  AST_ABS: assert property (go && lo == LO_ABS_JUMP |=> DONE_O && PC_LOAD_O == TAKEN_O && !FLAGS_LOAD_O &&
    (!TAKEN_O || PC_O == $past(DEST_ADDR_I))) else $error("abs jump wrong");
  AST_REL: assert property (go && lo == LO_REL_JUMP |=> !FLAGS_LOAD_O &&
    (!TAKEN_O || PC_O == $past(PC_I + {{8{DISP_I[7]}}, DISP_I}))) else $error("rel jump wrong");
  AST_DECBR: assert property (go && lo == LO_DEC_BRANCH |=> RESULT_LOAD_O && RESULT_O == $past(DST_I) - 8'h01 &&
    TAKEN_O == (RESULT_O != 8'h00) && !FLAGS_LOAD_O) else $error("dec branch wrong");
  AST_XOR: assert property (alu && OPCODE_I[7:4] == HI_XOR |=> FLAGS_LOAD_O && RESULT_O == $past(DST_I ^ SRC_I) &&
    FLAGS_O[FLAG_Z] == (RESULT_O == 8'h00) && FLAGS_O[FLAG_S] == RESULT_O[7] && !FLAGS_O[FLAG_V] &&
    FLAGS_O[FLAG_C] == $past(FLAGS_I[FLAG_C])) else $error("xor wrong");
  AST_SUBB: assert property (alu && OPCODE_I[7:4] == HI_SUB_BORROW |=> FLAGS_LOAD_O && FLAGS_O[FLAG_D] &&
    RESULT_O == $past(DST_I - SRC_I - {7'h00, FLAGS_I[FLAG_C]}) && FLAGS_O[FLAG_Z] == (RESULT_O == 8'h00))
    else $error("subtract with borrow wrong");
  AST_TAKEN: assert property (TAKEN_O |-> PC_LOAD_O && DONE_O) else $error("taken without load");
endmodule : bcod_chk
bind bcod_decoder bcod_chk u_chk (.*);

//--- dv/bcod_decoder_tb.sv
/* self-checking bench for the decoder.
   assumes the stack model and the checker beside it. */
`timescale 1ns/1ps
module bcod_decoder_tb
  import bcod_pkg::*;
;
  logic CORE_CLK_I = 1'b0, RST_I = 1'b1, INSTR_VALID_I = 1'b0;
  logic [7:0] OPCODE_I = 8'h00, DST_I = 8'h00, SRC_I = 8'h00, DISP_I = 8'hF0, FLAGS_I = 8'h00;
  logic [15:0] DEST_ADDR_I = 16'h1234, VECTOR_I = 16'h2000, PC_I = 16'h1000, SP_I = 16'h0100;
  logic DONE_O, TAKEN_O, PC_LOAD_O, SP_LOAD_O, FLAGS_LOAD_O, RESULT_LOAD_O, STACK_WR_O, STACK_WORD_O;
  logic [15:0] PC_O, SP_O, STACK_ADDR_O, STACK_DATA_O, m_pc, m_addr;
  logic [7:0] FLAGS_O, RESULT_O, m_fl;
  int failures = 0, cmp_count = 0;
  // {opcode, flags, taken}
  logic [16:0] rows [16] = '{17'h01BE0, 17'h03A41, 17'h05660, 17'h07A81, 17'h09621, 17'h0BA00, 17'h0D681,
    17'h0FA00, 17'h11601, 17'h13A61, 17'h15680, 17'h17A01, 17'h19620, 17'h1BA01, 17'h1DA80, 17'h1F601};
  bcod_decoder u_dut (.*);
  bcod_cpu_model u_mem (.clk_i(CORE_CLK_I), .rst_i(RST_I), .wr_i(STACK_WR_O), .word_i(STACK_WORD_O),
    .addr_i(STACK_ADDR_O), .data_i(STACK_DATA_O), .pc_word_o(m_pc), .pc_addr_o(m_addr), .flag_byte_o(m_fl));
  initial begin
    forever #10 CORE_CLK_I = ~CORE_CLK_I;
  end
  task chkb(input string n, input logic a, e);
    cmp_count++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, a);
    end
  endtask : chkb
  task chkw(input string n, input logic [15:0] a, e);
    cmp_count++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, a);
    end
  endtask : chkw
  task issue(input logic [7:0] o, f);
    @(posedge CORE_CLK_I);
    OPCODE_I <= o;
    FLAGS_I <= f;
    INSTR_VALID_I <= 1'b1;
    @(posedge CORE_CLK_I);
    INSTR_VALID_I <= 1'b0;
    #1;
  endtask : issue
  task tally_and_finish;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge CORE_CLK_I);
    #1;
    chkb("done in reset", DONE_O, 1'b0);
    chkw("pc in reset", PC_O, 16'h0000);
    @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      issue(rows[i][16:9], rows[i][8:1]);
      chkb("taken", TAKEN_O, rows[i][0]);
      chkb("flags load", FLAGS_LOAD_O, 1'b0);
      if (rows[i][0]) chkw("jump pc", PC_O, rows[i][10] ? 16'h0FF0 : 16'h1234);
    end
    $display("condition rows done");
    DST_I <= 8'h01;
    issue(8'h3A, 8'h00);
    chkb("decbr last", TAKEN_O, 1'b0);
    chkw("decbr result", {8'h00, RESULT_O}, 16'h0000);
    DST_I <= 8'h00;
    issue(8'h3A, 8'h00);
    chkw("decbr pc", PC_O, 16'h0FF0);
    $display("decrement branch done");
    DST_I <= 8'hA5;
    SRC_I <= 8'hA5;
    issue(8'hB2, 8'h9C);
    chkw("xor flags", {10'h000, FLAGS_O[7:2]}, 16'h0033);
    DST_I <= 8'h10;
    SRC_I <= 8'h01;
    issue(8'h37, 8'h80);
    chkw("subb result", {8'h00, RESULT_O}, 16'h000E);
    chkw("subb flags", {10'h000, FLAGS_O[7:2]}, 16'h0003);
    $display("alu done");
    issue(OP_TRAP, 8'h5A);
    chkb("trap idle first", STACK_WR_O, 1'b0);
    @(posedge CORE_CLK_I);
    #1;
    chkb("trap push", STACK_WR_O, 1'b1);
    issue(8'h8D, 8'h5A);
    chkb("refused", TAKEN_O, 1'b0);
    chkb("trap done", DONE_O, 1'b1);
    chkw("trap pc", PC_O, 16'h2000);
    chkw("trap sp", SP_O, 16'h00FD);
    chkw("pushed pc", m_pc, 16'h1000);
    chkw("pushed at", m_addr, 16'h00FE);
    chkw("pushed flags", {8'h00, m_fl}, 16'h005A);
    $display("trap done");
    tally_and_finish;
  end
endmodule : bcod_decoder_tb
